//--- rtl/iexs_pkg.sv
// Package for the instruction execute subset block: register map, field
// positions, opcode patterns, phase and operation encodings, carriers.
// Assumes a single pclk domain and a 16-bit program word.
package iexs_pkg;

	// ********************************************************************
	// Register map (byte offsets on the APB window)
	// ********************************************************************
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_ACC    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_BANK   = 8'h0c;
	localparam logic [7:0] OFF_PC     = 8'h10;
	localparam logic [7:0] OFF_INDEX  = 8'h14;

	// Control register bit positions
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_EXT    = 1;
	localparam int CTRL_HALTED = 2;
	localparam int CTRL_BADOP  = 3;

	// Reset values
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic [4:0] STAT_RST = 5'h00;

	// ********************************************************************
	// Data memory geometry and addressing
	// ********************************************************************
	localparam int         DM_ADDR_W     = 12;
	localparam int         BANK_W        = DM_ADDR_W - 8;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT  = 8'h60;

	// ********************************************************************
	// Opcode patterns
	// ********************************************************************
	localparam logic [5:0] OP_AND_HI   = 6'h05;
	localparam logic [7:0] OP_BC_HI    = 8'he2;
	localparam logic [7:0] OP_LOAD_LITERAL_TO_ACCUMULATOR_HI = 8'h0e;
	localparam logic [6:0] OP_STORE_ACCUMULATOR_TO_FILE_HI = 7'h37;
	localparam logic [6:0] OP_NEGATE_FILE_REGISTER_HI  = 7'h36;
	localparam logic [3:0] OP_NOP2_HI  = 4'hf;
	localparam logic [15:0] NOP_WORD   = 16'h0000;

	typedef enum logic [4:0] {
		PH_HALT  = 5'h01,
		PH_DEC   = 5'h02,
		PH_READ  = 5'h04,
		PH_PROC  = 5'h08,
		PH_WRITE = 5'h10
	} iexs_phase_e;

	typedef enum logic [2:0] {
		OPK_IDLE  = 3'h0,
		OPK_AND   = 3'h1,
		OPK_BC    = 3'h2,
		OPK_LOAD_LITERAL_TO_ACCUMULATOR = 3'h3,
		OPK_STORE_ACCUMULATOR_TO_FILE = 3'h4,
		OPK_NEGATE_FILE_REGISTER  = 3'h5,
		OPK_BAD   = 3'h6
	} iexs_op_e;

	// Bit 0 carry ... bit 4 negative
	typedef struct packed {
		logic n;
		logic signed_wrap_flag;
		logic z;
		logic half_carry_flag;
		logic c;
	} iexs_flags_s;

	typedef struct packed {
		iexs_op_e   op;
		logic       dest_file;
		logic       access;
		logic [7:0] operand;
	} iexs_dec_s;

	typedef struct packed {
		logic [DM_ADDR_W-1:0] addr;
		logic [7:0]           wdata;
		logic                 we;
		logic                 re;
	} iexs_dm_req_s;

endpackage

//--- rtl/iexs_core.sv
// Executes a subset of an 8-bit core instruction set in four-phase cycles.
// Program memory and data memory sit on pclk; data memory reads return one
// cycle after the read strobe. Software reaches the registers over APB.
//
// Summary of operation
// - AND-with-file ANDs the accumulator with the file register, sets only N and Z, result to accumulator when d is 0.
// - With the destination bit set the result of a byte instruction goes back to the file register.
// - With access bit 0 the 8-bit file address is resolved inside the access bank.
// - With access bit 1 the address is the bank pointer register joined with the 8-bit file address.
// - With the extended set on, access bit 0 and file address at most 5Fh the operand is an indexed literal offset.
// - Branch-on-carry adds twice the signed offset to the incremented PC when carry is set and alters no flag.
// - Branch-on-carry takes one cycle not taken and two taken, the second being idle, landing at PC+2+2n.
// - Load-literal copies the 8-bit immediate to the accumulator in one cycle without touching flags.
// - Store-accumulator writes the accumulator to any file location without touching flags.
// - Negate replaces the file register with its two's complement and updates N, OV, C, DC and Z.
`timescale 1ns/1ns
`default_nettype none

module iexs_core #(
	parameter int PC_W = 21
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [PC_W-1:0]             prog_addr,
	input  wire logic [15:0]                 prog_word,
	output iexs_pkg::iexs_dm_req_s           dm_req,
	input  wire logic [7:0]                  dm_rdata
);

	// ********************************************************************
	// Parameter check
	// ********************************************************************
	if (PC_W < 9 || PC_W > 32) begin : g_bad_pc_w
		$error("PC_W must lie between 9 and 32");
	end

	// ********************************************************************
	// Decode helpers
	// ********************************************************************
	function automatic iexs_pkg::iexs_dec_s decode(input logic [15:0] w);
		iexs_pkg::iexs_dec_s d;
		d.op        = iexs_pkg::OPK_BAD;
		d.dest_file = w[9];
		d.access    = w[8];
		d.operand   = w[7:0];
		if (w == iexs_pkg::NOP_WORD || w[15:12] == iexs_pkg::OP_NOP2_HI) begin
			d.op = iexs_pkg::OPK_IDLE;
		end else if (w[15:10] == iexs_pkg::OP_AND_HI) begin
			d.op = iexs_pkg::OPK_AND;
		end else if (w[15:8] == iexs_pkg::OP_BC_HI) begin
			d.op = iexs_pkg::OPK_BC;
		end else if (w[15:8] == iexs_pkg::OP_LOAD_LITERAL_TO_ACCUMULATOR_HI) begin
			d.op = iexs_pkg::OPK_LOAD_LITERAL_TO_ACCUMULATOR;
		end else if (w[15:9] == iexs_pkg::OP_STORE_ACCUMULATOR_TO_FILE_HI) begin
			d.op        = iexs_pkg::OPK_STORE_ACCUMULATOR_TO_FILE;
			d.dest_file = 1'b1;
		end else if (w[15:9] == iexs_pkg::OP_NEGATE_FILE_REGISTER_HI) begin
			d.op        = iexs_pkg::OPK_NEGATE_FILE_REGISTER;
			d.dest_file = 1'b1;
		end
		return d;
	endfunction

	function automatic logic [iexs_pkg::DM_ADDR_W-1:0] file_addr(
		input iexs_pkg::iexs_dec_s           d,
		input logic                          ext,
		input logic [iexs_pkg::BANK_W-1:0]   bank,
		input logic [iexs_pkg::DM_ADDR_W-1:0] index
	);
		logic [iexs_pkg::DM_ADDR_W-1:0] a;
		a = {bank, d.operand};
		if (!d.access) begin
			if (ext && d.operand <= iexs_pkg::INDEXED_LIMIT) begin
				a = index + {{iexs_pkg::BANK_W{1'b0}}, d.operand};
			end else if (d.operand < iexs_pkg::ACCESS_SPLIT) begin
				a = {{iexs_pkg::BANK_W{1'b0}}, d.operand};
			end else begin
				a = {{iexs_pkg::BANK_W{1'b1}}, d.operand};
			end
		end
		return a;
	endfunction

	// ********************************************************************
	// State
	// ********************************************************************
	iexs_pkg::iexs_phase_e              phase_reg,  phase_next;
	iexs_pkg::iexs_dec_s                dec_reg,    dec_next;
	iexs_pkg::iexs_flags_s              flags_reg,  flags_next;
	logic [7:0]                         acc_reg,    acc_next;
	logic [PC_W-1:0]                    pc_reg,     pc_next;
	logic [iexs_pkg::BANK_W-1:0]        bank_reg,   bank_next;
	logic [iexs_pkg::DM_ADDR_W-1:0]     index_reg,  index_next;
	logic [iexs_pkg::DM_ADDR_W-1:0]     addr_reg,   addr_next;
	logic [7:0]                         res_reg,    res_next;
	logic                               fwr_reg,    fwr_next;
	logic                               taken_reg,  taken_next;
	logic                               idle_reg,   idle_next;
	logic                               run_reg,    run_next;
	logic                               ext_reg,    ext_next;
	logic                               badop_reg,  badop_next;
	logic                               neg_hold_reg, neg_hold_next;
	logic [31:0]                        rdata_reg,  rdata_next;
	logic                               err_reg,    err_next;

	logic       wr_acc;
	logic       setup;
	logic       mapped;
	logic [7:0] neg;
	logic [4:0] neg_lo;

	assign wr_acc = psel && penable && pwrite;
	assign setup  = psel && !penable;
	assign mapped = paddr == iexs_pkg::OFF_CTRL || paddr == iexs_pkg::OFF_ACC ||
	                paddr == iexs_pkg::OFF_STATUS || paddr == iexs_pkg::OFF_BANK ||
	                paddr == iexs_pkg::OFF_PC || paddr == iexs_pkg::OFF_INDEX;
	assign neg    = 8'h00 - dm_rdata;
	assign neg_lo = {1'b0, ~dm_rdata[3:0]} + 5'h01;

	// ********************************************************************
	// Execution phases and software writes
	// ********************************************************************
	always_comb begin
		phase_next = phase_reg;
		dec_next   = dec_reg;
		flags_next = flags_reg;
		acc_next   = acc_reg;
		pc_next    = pc_reg;
		bank_next  = bank_reg;
		index_next = index_reg;
		addr_next  = addr_reg;
		res_next   = res_reg;
		fwr_next   = fwr_reg;
		taken_next = taken_reg;
		idle_next  = idle_reg;
		run_next   = run_reg;
		ext_next   = ext_reg;
		badop_next = badop_reg;
		neg_hold_next = neg_hold_reg;
		case (phase_reg)
			iexs_pkg::PH_HALT: phase_next = run_reg ? iexs_pkg::PH_DEC : iexs_pkg::PH_HALT;
			iexs_pkg::PH_DEC: begin
				// Second cycle of a taken branch runs as an idle instruction
				if (idle_reg) begin
					dec_next  = decode(iexs_pkg::NOP_WORD);
					idle_next = 1'b0;
				end else begin
					dec_next = decode(prog_word);
					addr_next = file_addr(decode(prog_word), ext_reg, bank_reg, index_reg);
					pc_next  = pc_reg + PC_W'(2);
				end
				fwr_next   = 1'b0;
				taken_next = 1'b0;
				phase_next = iexs_pkg::PH_READ;
			end
			iexs_pkg::PH_READ: phase_next = iexs_pkg::PH_PROC;
			iexs_pkg::PH_PROC: begin
				case (dec_reg.op)
					iexs_pkg::OPK_AND: begin
						res_next = acc_reg & dm_rdata;
						fwr_next = dec_reg.dest_file;
					end
					iexs_pkg::OPK_STORE_ACCUMULATOR_TO_FILE: begin
						res_next = acc_reg;
						fwr_next = 1'b1;
					end
					iexs_pkg::OPK_NEGATE_FILE_REGISTER: begin
						res_next = neg;
						fwr_next = 1'b1;
						neg_hold_next = neg_lo[4];
					end
					iexs_pkg::OPK_LOAD_LITERAL_TO_ACCUMULATOR: begin
						res_next = dec_reg.operand;
					end
					iexs_pkg::OPK_BC: begin
						taken_next = flags_reg.c;
					end
					iexs_pkg::OPK_BAD: badop_next = 1'b1;
					default: ;
				endcase
				phase_next = iexs_pkg::PH_WRITE;
			end
			iexs_pkg::PH_WRITE: begin
				case (dec_reg.op)
					iexs_pkg::OPK_AND: begin
						flags_next.n = res_reg[7];
						flags_next.z = res_reg == 8'h00;
						if (!dec_reg.dest_file) begin
							acc_next = res_reg;
						end
					end
					iexs_pkg::OPK_LOAD_LITERAL_TO_ACCUMULATOR: begin
						acc_next = res_reg;
					end
					iexs_pkg::OPK_NEGATE_FILE_REGISTER: begin
						flags_next.n                = res_reg[7];
						flags_next.z                = res_reg == 8'h00;
						flags_next.c                = res_reg == 8'h00;
						flags_next.signed_wrap_flag = res_reg == 8'h80;
						flags_next.half_carry_flag  = neg_hold_reg;
					end
					iexs_pkg::OPK_BC: begin
						if (taken_reg) begin
							pc_next   = pc_reg + PC_W'({{24{dec_reg.operand[7]}},
							                             dec_reg.operand, 1'b0});
							idle_next = 1'b1;
						end
					end
					default: ;
				endcase
				phase_next = run_reg ? iexs_pkg::PH_DEC : iexs_pkg::PH_HALT;
			end
			default: phase_next = iexs_pkg::PH_HALT;
		endcase
		// Software writes other than a bad-opcode clear take precedence over the core in the same cycle
		if (wr_acc) begin
			case (paddr)
				iexs_pkg::OFF_CTRL: begin
					run_next = pwdata[iexs_pkg::CTRL_RUN];
					ext_next = pwdata[iexs_pkg::CTRL_EXT];
					// A new bad opcode in the same cycle keeps the flag set
					if (pwdata[iexs_pkg::CTRL_BADOP] &&
					    !(phase_reg == iexs_pkg::PH_PROC && dec_reg.op == iexs_pkg::OPK_BAD)) begin
						badop_next = 1'b0;
					end
				end
				iexs_pkg::OFF_ACC:    acc_next   = pwdata[7:0];
				iexs_pkg::OFF_STATUS: flags_next = pwdata[4:0];
				iexs_pkg::OFF_BANK:   bank_next  = pwdata[iexs_pkg::BANK_W-1:0];
				iexs_pkg::OFF_PC:     pc_next    = {pwdata[PC_W-1:1], 1'b0};
				iexs_pkg::OFF_INDEX:  index_next = pwdata[iexs_pkg::DM_ADDR_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= iexs_pkg::PH_HALT;
			dec_reg   <= '0;
			flags_reg <= iexs_pkg::STAT_RST;
			acc_reg   <= iexs_pkg::ACC_RST;
			pc_reg    <= '0;
			bank_reg  <= '0;
			index_reg <= '0;
			addr_reg  <= '0;
			res_reg   <= 8'h00;
			fwr_reg   <= 1'b0;
			taken_reg <= 1'b0;
			idle_reg  <= 1'b0;
			run_reg   <= 1'b0;
			ext_reg   <= 1'b0;
			badop_reg <= 1'b0;
			neg_hold_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			dec_reg   <= dec_next;
			flags_reg <= flags_next;
			acc_reg   <= acc_next;
			pc_reg    <= pc_next;
			bank_reg  <= bank_next;
			index_reg <= index_next;
			addr_reg  <= addr_next;
			res_reg   <= res_next;
			fwr_reg   <= fwr_next;
			taken_reg <= taken_next;
			idle_reg  <= idle_next;
			run_reg   <= run_next;
			ext_reg   <= ext_next;
			badop_reg <= badop_next;
			neg_hold_reg <= neg_hold_next;
		end
	end

	// ********************************************************************
	// APB read side
	// ********************************************************************
	// Read data is captured in the setup cycle so the slave answers with no wait
	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup) begin
			err_next   = !mapped;
			rdata_next = 32'h0000_0000;
			case (paddr)
				iexs_pkg::OFF_CTRL: begin
					rdata_next[iexs_pkg::CTRL_RUN]    = run_reg;
					rdata_next[iexs_pkg::CTRL_EXT]    = ext_reg;
					rdata_next[iexs_pkg::CTRL_HALTED] = phase_reg == iexs_pkg::PH_HALT;
					rdata_next[iexs_pkg::CTRL_BADOP]  = badop_reg;
				end
				iexs_pkg::OFF_ACC:    rdata_next[7:0] = acc_reg;
				iexs_pkg::OFF_STATUS: rdata_next[4:0] = flags_reg;
				iexs_pkg::OFF_BANK:   rdata_next[iexs_pkg::BANK_W-1:0] = bank_reg;
				iexs_pkg::OFF_PC:     rdata_next[PC_W-1:0] = pc_reg;
				iexs_pkg::OFF_INDEX:  rdata_next[iexs_pkg::DM_ADDR_W-1:0] = index_reg;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
			err_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign prdata       = rdata_reg;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && err_reg;
	assign prog_addr    = pc_reg;
	assign dm_req.addr  = addr_reg;
	assign dm_req.wdata = res_reg;
	assign dm_req.re    = phase_reg == iexs_pkg::PH_READ &&
	                      dec_reg.op != iexs_pkg::OPK_IDLE && dec_reg.op != iexs_pkg::OPK_BAD;
	assign dm_req.we    = phase_reg == iexs_pkg::PH_WRITE && fwr_reg;

endmodule

`default_nettype wire

//--- test/iexs_mem_model.sv
// Program and data memory facing the execute block.
// Assumes a combinational program read and a one-cycle data read latency.
`timescale 1ns/1ns
`default_nettype none
module iexs_mem_model #(
	parameter int PC_W = 21
) (
	input  wire logic                   pclk,
	input  wire logic [PC_W-1:0]        prog_addr,
	output logic      [15:0]            prog_word,
	input  wire iexs_pkg::iexs_dm_req_s dm_req,
	output logic      [7:0]             dm_rdata
);
	// ****************
	// Storage
	// ****************
	bit   [15:0] prog_mem [256];
	bit   [7:0]  dmem     [4096];
	logic [7:0]  rd_q;
	logic        rd_v;
	assign prog_word = prog_mem[prog_addr[8:1]];
	// Stale data is inverted so a late sample never matches by luck
	assign dm_rdata = rd_v ? rd_q : ~rd_q;
	always @(posedge pclk) begin
		rd_v <= dm_req.re;
		if (dm_req.re) begin
			rd_q <= dmem[dm_req.addr];
		end
		if (dm_req.we) begin
			dmem[dm_req.addr] <= dm_req.wdata;
		end
	end
endmodule
`default_nettype wire

//--- test/iexs_core_assertions.sv
// Port checker for the execute block.
// Assumes the word shown in decode is the one whose read follows.
`timescale 1ns/1ns
`default_nettype none
module iexs_core_assertions #(
	parameter int PC_W = 21
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [PC_W-1:0]        prog_addr,
	input wire logic [15:0]            prog_word,
	input wire iexs_pkg::iexs_dm_req_s dm_req,
	input wire logic [7:0]             dm_rdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] w_reg;
	logic        fop;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg <= 16'h0000;
		end else begin
			w_reg <= prog_word;
		end
	end
	assign fop = w_reg[15:10] == iexs_pkg::OP_AND_HI || w_reg[15:9] == iexs_pkg::OP_STORE_ACCUMULATOR_TO_FILE_HI
		|| w_reg[15:9] == iexs_pkg::OP_NEGATE_FILE_REGISTER_HI;
	// ****************
	// Write slot sequences
	// ****************
	sequence s_write;
		##1 !dm_req.we ##1 dm_req.we ##1 !dm_req.we;
	endsequence
	sequence s_no_write;
		##1 !dm_req.we [*3];
	endsequence
	property p_and_acc;
		dm_req.re && w_reg[15:9] == {iexs_pkg::OP_AND_HI, 1'b0} |-> s_no_write;
	endproperty
	a_and_acc: assert property (p_and_acc) else $error("and to acc wrote file");
	property p_and_file;
		dm_req.re && w_reg[15:9] == {iexs_pkg::OP_AND_HI, 1'b1} |-> s_write;
	endproperty
	a_and_file: assert property (p_and_file) else $error("and to file missed write");
	property p_access_hi;
		dm_req.re && fop && !w_reg[8] && w_reg[7:0] >= iexs_pkg::ACCESS_SPLIT
			|-> dm_req.addr == {4'hf, w_reg[7:0]};
	endproperty
	a_access_hi: assert property (p_access_hi) else $error("access bank address wrong");
	property p_bc;
		dm_req.re && w_reg[15:8] == iexs_pkg::OP_BC_HI |-> s_no_write;
	endproperty
	a_bc: assert property (p_bc) else $error("branch wrote file");
	property p_load_literal_to_accumulator;
		dm_req.re && w_reg[15:8] == iexs_pkg::OP_LOAD_LITERAL_TO_ACCUMULATOR_HI |-> s_no_write;
	endproperty
	a_load_literal_to_accumulator: assert property (p_load_literal_to_accumulator) else $error("literal load wrote file");
	property p_store_accumulator_to_file;
		dm_req.re && w_reg[15:9] == iexs_pkg::OP_STORE_ACCUMULATOR_TO_FILE_HI |-> s_write;
	endproperty
	a_store_accumulator_to_file: assert property (p_store_accumulator_to_file) else $error("store missed write");
	property p_negate_file_register;
		dm_req.re && w_reg[15:9] == iexs_pkg::OP_NEGATE_FILE_REGISTER_HI |-> s_write;
	endproperty
	a_negate_file_register: assert property (p_negate_file_register) else $error("negate missed write");
	property p_rd_gap;
		dm_req.re |=> !dm_req.re [*3];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("reads closer than 4");
	property p_idle;
		dm_req.re |-> w_reg != iexs_pkg::NOP_WORD && w_reg[15:12] != iexs_pkg::OP_NOP2_HI;
	endproperty
	a_idle: assert property (p_idle) else $error("idle word caused read");
	property p_err;
		pslverr |-> psel && penable && pready;
	endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_rdata;
		psel && penable |=> $stable(prdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
bind iexs_core iexs_core_assertions #(.PC_W(PC_W)) iexs_core_assertions_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.prog_addr(prog_addr), .prog_word(prog_word), .dm_req(dm_req), .dm_rdata(dm_rdata));
`default_nettype wire

//--- test/instruction_execute_subset_tb_top.sv
// Self-checking bench for the execute block.
// Assumes the memory model answers the block's program and data ports.
`timescale 1ns/1ns
`default_nettype none
module instruction_execute_subset_tb_top;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]             paddr, dm_rdata, k1, v20, v21, v22;
	logic [31:0]            pwdata, prdata, rd;
	logic [20:0]            prog_addr;
	logic [15:0]            prog_word;
	iexs_pkg::iexs_dm_req_s dm_req;
	int                     n_fail, compares, cyc, t2, t22;
	integer                 seed;
	iexs_core #(.PC_W(21)) iexs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_word(prog_word),
		.dm_req(dm_req), .dm_rdata(dm_rdata));
	iexs_mem_model #(.PC_W(21)) iexs_mem_model_i (.pclk(pclk), .prog_addr(prog_addr),
		.prog_word(prog_word), .dm_req(dm_req), .dm_rdata(dm_rdata));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Marks first decode past word 0 and first decode past word 10, the branch target after the skipped word
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (prog_addr === 21'd2 && t2 < 0) begin
			t2 <= cyc;
		end
		if (prog_addr === 21'd22 && t22 < 0) begin
			t22 <= cyc;
		end
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Lets the self loop settle, then halts the core
	task automatic run_to(input logic [20:0] a);
		int n;
		n = 0;
		while (prog_addr !== a && n < 500) begin
			@(posedge pclk);
			n = n + 1;
		end
		repeat (12) @(posedge pclk);
		apb(1'b1, iexs_pkg::OFF_CTRL, 32'h0);
		repeat (10) @(posedge pclk);
	endtask
	initial begin
		logic [7:0] offs [6];
		offs = '{iexs_pkg::OFF_CTRL, iexs_pkg::OFF_ACC, iexs_pkg::OFF_STATUS,
			iexs_pkg::OFF_BANK, iexs_pkg::OFF_PC, iexs_pkg::OFF_INDEX};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{n_fail, compares, cyc} = '0;
		t2 = -1;
		t22 = -1;
		seed = 32'hd015864d;
		k1 = 8'($random(seed));
		v20 = 8'($random(seed));
		v21 = 8'($random(seed));
		v22 = 8'($random(seed)) | 8'h01;
		iexs_mem_model_i.prog_mem[0] = {8'h0e, k1};
		iexs_mem_model_i.prog_mem[1] = 16'h6e70;
		iexs_mem_model_i.prog_mem[2] = 16'h6f10;
		iexs_mem_model_i.prog_mem[3] = 16'h1620;
		iexs_mem_model_i.prog_mem[4] = 16'h1521;
		iexs_mem_model_i.prog_mem[5] = 16'h6c22;
		iexs_mem_model_i.prog_mem[6] = 16'he202;
		iexs_mem_model_i.prog_mem[7] = 16'h6c23;
		iexs_mem_model_i.prog_mem[8] = 16'he201;
		iexs_mem_model_i.prog_mem[9] = 16'h0e55;
		iexs_mem_model_i.prog_mem[11] = 16'he2ff;
		iexs_mem_model_i.prog_mem[32] = 16'h6e05;
		// Word outside the subset: runs as idle and raises the sticky flag
		iexs_mem_model_i.prog_mem[33] = 16'h0100;
		iexs_mem_model_i.prog_mem[34] = 16'he2ff;
		iexs_mem_model_i.dmem[12'h020] = v20;
		iexs_mem_model_i.dmem[12'h221] = v21;
		iexs_mem_model_i.dmem[12'h022] = v22;
		iexs_mem_model_i.dmem[12'hf70] = ~k1;
		iexs_mem_model_i.dmem[12'h210] = ~k1;
		iexs_mem_model_i.dmem[12'h305] = ~k1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset value", rd, (i == 0) ? 32'h4 : 32'h0);
		end
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		$display("TEST reset done");
		apb(1'b1, iexs_pkg::OFF_BANK, 32'h2);
		apb(1'b1, iexs_pkg::OFF_CTRL, 32'h1);
		run_to(21'd22);
		apb(1'b0, iexs_pkg::OFF_ACC, 32'h0);
		chk("acc", rd, {24'h0, k1 & v21});
		apb(1'b0, iexs_pkg::OFF_STATUS, 32'h0);
		chk("status", rd, 32'h7);
		apb(1'b0, iexs_pkg::OFF_PC, 32'h0);
		chk("pc", rd, 32'd22);
		chk("cycles", t22 - t2, 32'd40);
		chk("access hi", {24'h0, iexs_mem_model_i.dmem[12'hf70]}, {24'h0, k1});
		chk("banked", {24'h0, iexs_mem_model_i.dmem[12'h210]}, {24'h0, k1});
		chk("and file", {24'h0, iexs_mem_model_i.dmem[12'h020]}, {24'h0, k1 & v20});
		chk("negate", {24'h0, iexs_mem_model_i.dmem[12'h022]}, {24'h0, 8'(-v22)});
		chk("negate 0", {24'h0, iexs_mem_model_i.dmem[12'h023]}, 32'h0);
		$display("TEST program done");
		apb(1'b1, iexs_pkg::OFF_INDEX, 32'h300);
		apb(1'b1, iexs_pkg::OFF_PC, 32'h40);
		apb(1'b1, iexs_pkg::OFF_CTRL, 32'h3);
		run_to(21'h44);
		chk("indexed", {24'h0, iexs_mem_model_i.dmem[12'h305]}, {24'h0, k1 & v21});
		apb(1'b0, iexs_pkg::OFF_CTRL, 32'h0);
		chk("bad opcode", rd, 32'hc);
		apb(1'b1, iexs_pkg::OFF_CTRL, 32'h8);
		apb(1'b0, iexs_pkg::OFF_CTRL, 32'h0);
		chk("bad opcode clear", rd, 32'h4);
		$display("TEST indexed done");
		end_sim();
	end
endmodule
`default_nettype wire
